//--- common/afcc_pkg.sv
/*
 Constants, types and carriers shared by the acquisition FIFO command control.
 Assumes a single 25 MHz host-bus clock and byte-wide port accesses.
*/
`default_nettype none
package afcc_pkg;

  // Port offsets from base
  localparam logic [2:0] OFS_DATA = 3'h1;
  localparam logic [2:0] OFS_STATUS = 3'h2;
  localparam logic [2:0] OFS_AUX = 3'h7;

  // Auxiliary control bit positions
  localparam int AUX_TRIG_BIT = 7;
  localparam int AUX_FLUSH_DATA_BIT = 6;
  localparam int AUX_FLUSH_SCAN_BIT = 5;
  localparam int AUX_STOP_BIT = 4;
  localparam int AUX_RATE_LSB = 1;
  localparam int AUX_ACCESS_BIT = 0;

  // Status bit positions
  localparam int STAT_IDLE_BIT = 7;
  localparam int STAT_TRIG_BIT = 6;
  localparam int STAT_LOST_BIT = 5;
  localparam int STAT_FULL_BIT = 2;
  localparam int STAT_AFULL_BIT = 1;
  localparam int STAT_EMPTY_BIT = 0;

  // Values after reset; thresholds also after a data flush
  localparam logic [7:0] THR_LOW_DEFAULT = 8'h07;
  localparam logic [7:0] THR_HIGH_DEFAULT = 8'h00;
  localparam logic [7:0] THR_HIGH_MASK = 8'h0F;
  localparam logic ACCESS_RESET = 1'b1;
  localparam logic [1:0] RATE_RESET = 2'h0;

  // Sizes
  localparam int FIFO_DEPTH = 16;
  localparam int DATA_W = 8;
  localparam int SCAN_DEPTH = 2048;
  localparam int THR_BYTES = 4;

  // Threshold byte indices
  localparam logic [1:0] THR_AE_LO = 2'h0;
  localparam logic [1:0] THR_AE_HI = 2'h1;
  localparam logic [1:0] THR_AF_LO = 2'h2;
  localparam logic [1:0] THR_AF_HI = 2'h3;

  // Scan rate codes
  localparam logic [1:0] RATE_100K = 2'h0;
  localparam logic [1:0] RATE_50K = 2'h1;
  localparam logic [1:0] RATE_25K = 2'h2;

  // Conversion periods
  localparam int CLK_PERIOD_NS = 40;
  localparam int PERIOD_100K_NS = 10000;
  localparam int PERIOD_50K_NS = 20000;
  localparam int PERIOD_25K_NS = 40000;
  localparam logic [9:0] CYC_100K = 10'(PERIOD_100K_NS / CLK_PERIOD_NS);
  localparam logic [9:0] CYC_50K = 10'(PERIOD_50K_NS / CLK_PERIOD_NS);
  localparam logic [9:0] CYC_25K = 10'(PERIOD_25K_NS / CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    ACQ_IDLE = 3'h1,
    ACQ_ARMED = 3'h2,
    ACQ_RUN = 3'h4
  } afcc_acq_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } afcc_bus_req_t;

  typedef struct packed {
    logic full;
    logic afull;
    logic empty;
  } afcc_flags_t;

endpackage
`default_nettype wire

//--- rtl/afcc_top.sv
/*
 Acquisition FIFO command control: auxiliary command port, threshold program
 mode, sample FIFO with flags, acquisition state and scan-list entry pairing.
 Assumes host port strobes and converter samples are synchronous to sys_clk_i;
 the external trigger pin is asynchronous.
*/
// Notes on behaviour
// - Data flush empties FIFO, clears full flags
// - Every data flush restores default thresholds
// - Scan queue holds 2048 two-byte words
// - Only stop ends a started acquisition
// - Samples arriving at full FIFO are dropped
// - Two thresholds default seven; almost-empty unused
// - Almost-full threshold spans zero to 4095
// - Program mode: data port reaches threshold bytes
// - Byte order AE low, AE high, AF low/high
// - Rate field 00/01/10/11 selects 100/50/25/50k
// - Command bits self-clear; access bit latched
// - Status bits 2:0 show full, afull, empty
// - Trigger starts now, or arms external edge
`timescale 1ns/1ps
`default_nettype none

module afcc_fifo #(
  parameter int WIDTH = afcc_pkg::DATA_W,
  parameter int DEPTH = afcc_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic flush_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic [$clog2(DEPTH+1)-1:0] count_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("afcc_fifo depth must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  wire logic push;
  wire logic pop;

  assign in_ready_o = (count != CW'(DEPTH)) && !flush_i;
  assign out_valid_o = (count != '0) && !flush_i;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[rd_ptr];
  assign count_o = count;

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (flush_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= push ? AW'(wr_ptr + 1'b1) : wr_ptr;
      rd_ptr <= pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
      count <= CW'(count + CW'(push) - CW'(pop));
    end
  end
endmodule

module afcc_top #(
  parameter int FIFO_DEPTH = afcc_pkg::FIFO_DEPTH,
  parameter int SCAN_DEPTH = afcc_pkg::SCAN_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Host port
  input wire afcc_pkg::afcc_bus_req_t bus_req_i,
  output logic [7:0] bus_rdata_o,
  // Trigger configuration and pin
  input wire logic trig_ext_sel_i,
  input wire logic trig_falling_i,
  input wire logic ext_trig_pin_i,
  // Converter samples
  input wire logic adc_valid_i,
  input wire logic [7:0] adc_data_i,
  output logic adc_ready_o,
  // Acquisition control
  output logic acq_run_o,
  output logic conv_tick_o,
  output logic [1:0] scan_rate_o,
  // Scan-list queue
  input wire logic scan_byte_wr_i,
  input wire logic [7:0] scan_byte_i,
  output logic [15:0] scan_word_o,
  output logic scan_word_valid_o,
  output logic scan_flush_o,
  output logic [11:0] scan_count_o,
  output logic scan_full_o,
  // FIFO flags
  output afcc_pkg::afcc_flags_t fifo_flags_o
);
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  generate
    if (FIFO_DEPTH > 4096 || FIFO_DEPTH < 8) begin : g_bad_fifo
      $error("afcc_top FIFO depth must lie between 8 and 4096");
    end
    if (SCAN_DEPTH < 1 || SCAN_DEPTH > 4095) begin : g_bad_scan
      $error("afcc_top scan depth must lie between 1 and 4095");
    end
  endgenerate

  function automatic logic [9:0] rate_cycles(input logic [1:0] code);
    case (code)
      afcc_pkg::RATE_100K: rate_cycles = afcc_pkg::CYC_100K;
      afcc_pkg::RATE_25K: rate_cycles = afcc_pkg::CYC_25K;
      default: rate_cycles = afcc_pkg::CYC_50K;
    endcase
  endfunction

  // Port decode
  wire logic aux_wr;
  wire logic data_wr;
  wire logic data_rd;
  wire logic stat_rd;
  wire logic cmd_trig;
  wire logic cmd_flush_data;
  wire logic cmd_flush_scan;
  wire logic cmd_stop;
  assign aux_wr = bus_req_i.wr && (bus_req_i.addr == afcc_pkg::OFS_AUX);
  assign data_wr = bus_req_i.wr && (bus_req_i.addr == afcc_pkg::OFS_DATA);
  assign data_rd = bus_req_i.rd && (bus_req_i.addr == afcc_pkg::OFS_DATA);
  assign stat_rd = bus_req_i.rd && (bus_req_i.addr == afcc_pkg::OFS_STATUS);
  // Commands exist only in the write cycle itself
  assign cmd_trig = aux_wr && bus_req_i.wdata[afcc_pkg::AUX_TRIG_BIT];
  assign cmd_flush_data = aux_wr && bus_req_i.wdata[afcc_pkg::AUX_FLUSH_DATA_BIT];
  assign cmd_flush_scan = aux_wr && bus_req_i.wdata[afcc_pkg::AUX_FLUSH_SCAN_BIT];
  assign cmd_stop = aux_wr && bus_req_i.wdata[afcc_pkg::AUX_STOP_BIT];

  // Access selector
  logic access;
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      access <= afcc_pkg::ACCESS_RESET;
    end else if (aux_wr) begin
      access <= bus_req_i.wdata[afcc_pkg::AUX_ACCESS_BIT];
    end
  end

  // Threshold bytes
  logic [7:0] thr [afcc_pkg::THR_BYTES];
  logic [1:0] thr_idx;
  wire logic prog_wr;
  wire logic prog_rd;
  wire logic [7:0] thr_mask;
  assign prog_wr = data_wr && !access;
  assign prog_rd = data_rd && !access;
  assign thr_mask = thr_idx[0] ? afcc_pkg::THR_HIGH_MASK : 8'hFF;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      thr[afcc_pkg::THR_AE_LO] <= afcc_pkg::THR_LOW_DEFAULT;
      thr[afcc_pkg::THR_AE_HI] <= afcc_pkg::THR_HIGH_DEFAULT;
      thr[afcc_pkg::THR_AF_LO] <= afcc_pkg::THR_LOW_DEFAULT;
      thr[afcc_pkg::THR_AF_HI] <= afcc_pkg::THR_HIGH_DEFAULT;
      thr_idx <= '0;
    end else if (cmd_flush_data) begin
      thr[afcc_pkg::THR_AE_LO] <= afcc_pkg::THR_LOW_DEFAULT;
      thr[afcc_pkg::THR_AE_HI] <= afcc_pkg::THR_HIGH_DEFAULT;
      thr[afcc_pkg::THR_AF_LO] <= afcc_pkg::THR_LOW_DEFAULT;
      thr[afcc_pkg::THR_AF_HI] <= afcc_pkg::THR_HIGH_DEFAULT;
      thr_idx <= '0;
    end else begin
      if (prog_wr) begin
        thr[thr_idx] <= bus_req_i.wdata & thr_mask;
      end
      if (prog_wr || prog_rd) begin
        thr_idx <= 2'(thr_idx + 1'b1);
      end
    end
  end

  // Sample FIFO
  wire logic fifo_in_valid;
  wire logic fifo_in_ready;
  wire logic fifo_out_valid;
  wire logic fifo_out_ready;
  wire logic [7:0] fifo_out_data;
  wire logic [CW-1:0] fifo_count;
  logic running;
  assign fifo_in_valid = adc_valid_i && running;
  assign fifo_out_ready = data_rd && access;
  assign adc_ready_o = fifo_in_ready;

  afcc_fifo #(
    .WIDTH(afcc_pkg::DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .flush_i(cmd_flush_data),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(adc_data_i),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data),
    .count_o(fifo_count)
  );

  // Flags; almost-empty threshold is stored only
  wire logic [12:0] free_bytes;
  wire logic [12:0] af_thr;
  wire afcc_pkg::afcc_flags_t next_flags;
  assign free_bytes = 13'(FIFO_DEPTH) - 13'(fifo_count);
  assign af_thr = {1'b0, thr[afcc_pkg::THR_AF_HI][3:0], thr[afcc_pkg::THR_AF_LO]};
  assign next_flags.full = (fifo_count == CW'(FIFO_DEPTH));
  assign next_flags.afull = (free_bytes <= af_thr);
  assign next_flags.empty = (fifo_count == '0);
  assign fifo_flags_o = next_flags;

  // Lost-sample latch, cleared by a status read
  logic lost;
  wire logic drop;
  assign drop = fifo_in_valid && !fifo_in_ready;
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lost <= 1'b0;
    end else if (drop) begin
      lost <= 1'b1;
    end else if (stat_rd) begin
      lost <= 1'b0;
    end
  end

  // Acquisition state
  afcc_pkg::afcc_acq_state_t state;
  afcc_pkg::afcc_acq_state_t next_state;
  logic trig_meta;
  logic trig_sync;
  logic trig_prev;
  wire logic trig_edge;
  assign trig_edge = trig_falling_i ? (trig_prev && !trig_sync) : (!trig_prev && trig_sync);

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      trig_meta <= 1'b0;
      trig_sync <= 1'b0;
      trig_prev <= 1'b0;
    end else begin
      trig_meta <= ext_trig_pin_i;
      trig_sync <= trig_meta;
      trig_prev <= trig_sync;
    end
  end

  always_comb begin
    next_state = state;
    if (cmd_stop) begin
      next_state = afcc_pkg::ACQ_IDLE;
    end else begin
      case (state)
        afcc_pkg::ACQ_IDLE: begin
          if (cmd_trig) begin
            next_state = trig_ext_sel_i ? afcc_pkg::ACQ_ARMED : afcc_pkg::ACQ_RUN;
          end
        end
        afcc_pkg::ACQ_ARMED: begin
          if (trig_edge) begin
            next_state = afcc_pkg::ACQ_RUN;
          end
        end
        afcc_pkg::ACQ_RUN: begin
          next_state = afcc_pkg::ACQ_RUN;
        end
        default: begin
          next_state = afcc_pkg::ACQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= afcc_pkg::ACQ_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Rate latched only with a trigger from idle
  logic [1:0] rate;
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rate <= afcc_pkg::RATE_RESET;
    end else if (cmd_trig && !cmd_stop && state == afcc_pkg::ACQ_IDLE) begin
      rate <= bus_req_i.wdata[afcc_pkg::AUX_RATE_LSB +: 2];
    end
  end

  // Conversion pacing; first tick on entry to run
  logic [9:0] tick_cnt;
  wire logic entering_run;
  wire logic [1:0] run_rate;
  // From idle the rate rides on the trigger write; from armed it is already latched
  assign run_rate = (state == afcc_pkg::ACQ_IDLE) ?
                    bus_req_i.wdata[afcc_pkg::AUX_RATE_LSB +: 2] : rate;
  assign running = (state == afcc_pkg::ACQ_RUN);
  assign entering_run = (next_state == afcc_pkg::ACQ_RUN) && !running;
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_cnt <= '0;
      conv_tick_o <= 1'b0;
    end else if (entering_run || (running && tick_cnt == '0)) begin
      tick_cnt <= 10'(rate_cycles(run_rate) - 1'b1);
      conv_tick_o <= 1'b1;
    end else begin
      tick_cnt <= running ? 10'(tick_cnt - 1'b1) : '0;
      conv_tick_o <= 1'b0;
    end
  end
  assign acq_run_o = running;
  assign scan_rate_o = rate;

  // Scan-list pairing, low byte first
  logic [7:0] scan_lo;
  logic scan_half;
  logic [11:0] scan_count;
  wire logic scan_room;
  assign scan_room = (scan_count < 12'(SCAN_DEPTH));
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scan_lo <= '0;
      scan_half <= 1'b0;
      scan_count <= '0;
      scan_word_o <= '0;
      scan_word_valid_o <= 1'b0;
      scan_flush_o <= 1'b0;
    end else begin
      scan_flush_o <= cmd_flush_scan;
      scan_word_valid_o <= 1'b0;
      if (cmd_flush_scan) begin
        scan_half <= 1'b0;
        scan_count <= '0;
      end else if (scan_byte_wr_i && scan_room) begin
        scan_half <= !scan_half;
        if (!scan_half) begin
          scan_lo <= scan_byte_i;
        end else begin
          scan_word_o <= {scan_byte_i, scan_lo};
          scan_word_valid_o <= 1'b1;
          scan_count <= 12'(scan_count + 1'b1);
        end
      end
    end
  end
  assign scan_count_o = scan_count;
  assign scan_full_o = !scan_room;

  // Read data
  wire logic [7:0] status_byte;
  wire logic [7:0] data_byte;
  assign status_byte = {!running, running, lost, 2'b00,
                        next_flags.full, next_flags.afull, next_flags.empty};
  assign data_byte = access ? (fifo_out_valid ? fifo_out_data : 8'h00) : thr[thr_idx];
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus_rdata_o <= 8'h00;
    end else if (data_rd) begin
      bus_rdata_o <= data_byte;
    end else if (stat_rd) begin
      bus_rdata_o <= status_byte;
    end else if (bus_req_i.rd) begin
      bus_rdata_o <= 8'h00;
    end
  end
endmodule
`default_nettype wire

//--- tb/afcc_asserts.sv
/*
 Concurrent checks on the afcc_top ports.
 Assumes binding into afcc_top with one clock and an active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module afcc_asserts #(
  parameter int FIFO_DEPTH = 16,
  parameter int SCAN_DEPTH = 2048
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Host port
  input wire afcc_pkg::afcc_bus_req_t bus_req_i,
  input wire logic [7:0] bus_rdata_o,
  // Trigger
  input wire logic trig_ext_sel_i,
  input wire logic trig_falling_i,
  input wire logic ext_trig_pin_i,
  // Converter
  input wire logic adc_valid_i,
  input wire logic [7:0] adc_data_i,
  input wire logic adc_ready_o,
  // Acquisition
  input wire logic acq_run_o,
  input wire logic conv_tick_o,
  input wire logic [1:0] scan_rate_o,
  // Scan list
  input wire logic scan_byte_wr_i,
  input wire logic [7:0] scan_byte_i,
  input wire logic [15:0] scan_word_o,
  input wire logic scan_word_valid_o,
  input wire logic scan_flush_o,
  input wire logic [11:0] scan_count_o,
  input wire logic scan_full_o,
  // Flags
  input wire afcc_pkg::afcc_flags_t fifo_flags_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic aux_wr;
  logic start;
  logic seen;
  logic [10:0] gap;
  logic [10:0] want;
  assign aux_wr = bus_req_i.wr && bus_req_i.addr == afcc_pkg::OFS_AUX;
  assign start = aux_wr && bus_req_i.wdata[7] && !bus_req_i.wdata[4] && !acq_run_o;
  assign want = scan_rate_o == afcc_pkg::RATE_100K ? 11'(afcc_pkg::CYC_100K) :
    scan_rate_o == afcc_pkg::RATE_25K ? 11'(afcc_pkg::CYC_25K) : 11'(afcc_pkg::CYC_50K);
  // Cycles since the last conversion tick of this run
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gap <= 11'h000;
      seen <= 1'b0;
    end else if (!acq_run_o) begin
      gap <= 11'h000;
      seen <= 1'b0;
    end else if (conv_tick_o) begin
      gap <= 11'h001;
      seen <= 1'b1;
    end else begin
      gap <= gap + 11'h001;
    end
  end
  a_flush_clears: assert property (aux_wr && bus_req_i.wdata[6] |=> fifo_flags_o == 3'h1)
    else $error("flags wrong after data flush");
  a_stop_idles: assert property (aux_wr && bus_req_i.wdata[4] |=> !acq_run_o)
    else $error("still running after stop");
  a_run_holds: assert property (acq_run_o && !(aux_wr && bus_req_i.wdata[4]) |=> acq_run_o)
    else $error("run ended without stop");
  a_full_refuses: assert property (fifo_flags_o.full |-> !adc_ready_o)
    else $error("sample accepted while full");
  a_status_live: assert property (bus_req_i.rd && bus_req_i.addr == afcc_pkg::OFS_STATUS
    |=> bus_rdata_o[2:0] == $past(fifo_flags_o))
    else $error("status flags differ from live flags");
  a_trig_starts: assert property (start && !trig_ext_sel_i |=> acq_run_o && conv_tick_o)
    else $error("internal trigger did not start");
  a_rate_latch: assert property (start |=> scan_rate_o == $past(bus_req_i.wdata[2:1]))
    else $error("rate not latched with trigger");
  a_tick_gap: assert property (conv_tick_o && seen |-> gap == want)
    else $error("conversion spacing wrong");
  a_scan_flush: assert property (aux_wr && bus_req_i.wdata[5] |=> scan_flush_o ##1 !scan_flush_o)
    else $error("scan flush pulse wrong");
  c_flush: cover property (aux_wr && bus_req_i.wdata[6]);
  c_full: cover property (fifo_flags_o.full && adc_valid_i);
  c_slow: cover property (conv_tick_o && seen && scan_rate_o == afcc_pkg::RATE_25K);
endmodule
bind afcc_top afcc_asserts #(.FIFO_DEPTH(FIFO_DEPTH), .SCAN_DEPTH(SCAN_DEPTH)) u_asserts (.*);
`default_nettype wire

//--- tb/afcc_adc_model.sv
/*
 Converter model: one sample per conversion tick, counting up from 00.
 Assumes the device paces it with conv_tick_o.
*/
`timescale 1ns/1ps
`default_nettype none
module afcc_adc_model (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Pacing
  input wire logic conv_tick_o,
  // Samples
  output logic adc_valid_i,
  output logic [7:0] adc_data_i
);
  logic [7:0] next_val;
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      adc_valid_i <= 1'b0;
      adc_data_i <= 8'hFF;
      next_val <= 8'h00;
    end else if (conv_tick_o) begin
      adc_valid_i <= 1'b1;
      adc_data_i <= next_val;
      next_val <= next_val + 8'h01;
    end else begin
      adc_valid_i <= 1'b0;
      adc_data_i <= ~adc_data_i;
    end
  end
endmodule
`default_nettype wire

//--- tb/testbench.sv
/*
 Self-checking bench for afcc_top: host port accesses and expected values.
 Assumes the converter model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk_i;
  logic rst_b_i;
  afcc_pkg::afcc_bus_req_t bus_req_i;
  logic [7:0] bus_rdata_o;
  logic trig_ext_sel_i;
  logic trig_falling_i;
  logic ext_trig_pin_i;
  logic adc_valid_i;
  logic [7:0] adc_data_i;
  logic adc_ready_o;
  logic acq_run_o;
  logic conv_tick_o;
  logic [1:0] scan_rate_o;
  logic scan_byte_wr_i;
  logic [7:0] scan_byte_i;
  logic [15:0] scan_word_o;
  logic scan_word_valid_o;
  logic scan_flush_o;
  logic [11:0] scan_count_o;
  logic scan_full_o;
  afcc_pkg::afcc_flags_t fifo_flags_o;
  int err_total;
  int checked;
  logic [7:0] rv;
  afcc_top dut (.*);
  afcc_adc_model adc (.*);
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
    bus_req_i = {w, !w, a, d};
    wait_cyc(1);
    rv = bus_rdata_o;
    bus_req_i = '0;
    wait_cyc(1);
  endtask
  task automatic chk_rd(input logic [2:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    chk(16'(rv), 16'(exp));
  endtask
  // Four threshold bytes, byte 0 in the low bits
  task automatic thr(input logic [31:0] exp);
    for (int i = 0; i < 4; i++) chk_rd(3'h1, exp[8*i +: 8]);
  endtask
  task automatic end_sim;
    $display("Checks %0d, errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #1000000;
    err_total++;
    end_sim();
  end
  initial begin
    rst_b_i = 1'b0;
    bus_req_i = '0;
    trig_ext_sel_i = 1'b0;
    trig_falling_i = 1'b0;
    ext_trig_pin_i = 1'b0;
    scan_byte_wr_i = 1'b0;
    scan_byte_i = 8'h00;
    err_total = 0;
    checked = 0;
    wait_cyc(4);
    rst_b_i = 1'b1;
    chk_rd(3'h2, 8'h81);
    acc(1'b1, 3'h7, 8'h00);
    acc(1'b1, 3'h7, 8'h40);
    thr(32'h0007_0007);
    for (int i = 0; i < 4; i++) acc(1'b1, 3'h1, 8'(32'h000C_F300 >> (8 * i)));
    thr(32'h000C_0300);
    acc(1'b1, 3'h7, 8'h01);
    acc(1'b1, 3'h7, 8'h81);
    acc(1'b1, 3'h7, 8'h85);
    chk(16'(scan_rate_o), 16'(afcc_pkg::RATE_100K));
    // Three samples stored, then the fourth reaches the threshold
    wait_cyc(500);
    chk_rd(3'h2, 8'h40);
    wait_cyc(250);
    chk_rd(3'h2, 8'h42);
    wait_cyc(4000);
    chk_rd(3'h2, 8'h66);
    acc(1'b1, 3'h7, 8'h11);
    for (int i = 0; i < 8; i++) chk_rd(3'h1, 8'(i));
    chk_rd(3'h2, 8'h82);
    acc(1'b1, 3'h7, 8'h00);
    acc(1'b1, 3'h7, 8'h40);
    chk_rd(3'h2, 8'h81);
    thr(32'h0007_0007);
    acc(1'b1, 3'h7, 8'h01);
    for (int c = 1; c < 4; c++) begin
      acc(1'b1, 3'h7, {4'h8, 1'b0, 2'(c), 1'b1});
      chk(16'(scan_rate_o), 16'(c));
      wait_cyc(2100);
      acc(1'b1, 3'h7, 8'h11);
    end
    // Arm on the external source, then fire it
    trig_ext_sel_i = 1'b1;
    acc(1'b1, 3'h7, 8'h81);
    wait_cyc(5);
    chk(16'(acq_run_o), 16'h0000);
    ext_trig_pin_i = 1'b1;
    wait_cyc(6);
    chk(16'(acq_run_o), 16'h0001);
    acc(1'b1, 3'h7, 8'h11);
    // Falling edge at 25 kHz; the checker times the first interval
    trig_falling_i = 1'b1;
    acc(1'b1, 3'h7, 8'h85);
    wait_cyc(5);
    chk(16'(acq_run_o), 16'h0000);
    ext_trig_pin_i = 1'b0;
    wait_cyc(1100);
    chk(16'(acq_run_o), 16'h0001);
    chk(16'(scan_rate_o), 16'(afcc_pkg::RATE_25K));
    acc(1'b1, 3'h7, 8'h11);
    trig_ext_sel_i = 1'b0;
    acc(1'b1, 3'h7, 8'h21);
    scan_byte_i = 8'h34;
    scan_byte_wr_i = 1'b1;
    wait_cyc(1);
    scan_byte_i = 8'h12;
    wait_cyc(1);
    chk(16'(scan_word_valid_o), 16'h0001);
    scan_byte_wr_i = 1'b0;
    wait_cyc(2);
    chk(scan_word_o, 16'h1234);
    chk(16'(scan_count_o), 16'h0001);
    chk(16'(scan_full_o), 16'h0000);
    end_sim();
  end
endmodule
`default_nettype wire
